// [hdl/cls_defs.vh]
// constants for the communication loss supervisor
`ifndef CLS_DEFS_VH
`define CLS_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CLS_OFS_NODE      8'h00
`define CLS_OFS_RATE      8'h04
`define CLS_OFS_PTIMEOUT  8'h08
`define CLS_OFS_PREACT    8'h0C
`define CLS_OFS_APPLY     8'h10
`define CLS_OFS_FBEN      8'h14
`define CLS_OFS_FBREACT   8'h18
`define CLS_OFS_FBDELAY   8'h1C
`define CLS_OFS_STATUS    8'h20
`define CLS_OFS_FAULT     8'h24
`define CLS_OFS_SAFESPD   8'h28
`define CLS_OFS_SAFEFRQ   8'h2C
`define CLS_OFS_FILT      8'h30

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CLS_RST_NODE      16'h0001
`define CLS_RST_RATE      3'h4
`define CLS_RST_PTIMEOUT  16'h0064
`define CLS_RST_PREACT    3'h1
`define CLS_RST_FBREACT   3'h0
`define CLS_RST_FBDELAY   16'h0003

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define CLS_RATE_MIN      3'h1
`define CLS_RATE_MAX      3'h5
`define CLS_APPLY_DONE    1'b0
`define CLS_APPLY_RUN     1'b1
`define CLS_RE_NONE       3'h0
`define CLS_RE_FAULT      3'h1
`define CLS_RE_LAST       3'h2
`define CLS_RE_SAFE       3'h3
`define CLS_RE_FAULTALL   3'h4
`define CLS_RE_WARN       3'h5
`define CLS_FC_PANEL      16'h7081
`define CLS_FC_FIELDBUS   16'h7510
`define CLS_WC_PANEL      16'hA7EE
`define CLS_WC_FIELDBUS   16'hA7C1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLS_CLK_NS        4
`define CLS_TICK_NS       100000000
`define CLS_TICK_CYC      (`CLS_TICK_NS / `CLS_CLK_NS)
`define CLS_FILT_TAU_NS   850000000
`define CLS_FILT_SHIFT    4
`define CLS_FILT_CYC      (`CLS_FILT_TAU_NS / `CLS_CLK_NS / 16)

`endif

// [hdl/cls_loss_timer.v]
// break timer for one supervised link
`timescale 1ns/1ps

module cls_loss_timer
#(
	parameter CW = 16
)
(
	// clock and reset
	input  wire          mclk,
	input  wire          srst,
	// control
	input  wire          armed,
	input  wire          tick,
	input  wire          restart,
	input  wire [CW-1:0] limit,
	input  wire          strict,
	// result
	output reg           expired
);

	reg  [CW-1:0] count_reg;

	// saturate so a long break never wraps back under the limit
	always @(posedge mclk)
	begin
		if (srst || !armed || restart)
		begin
			count_reg <= {CW{1'b0}};
			expired   <= 1'b0;
		end
		else
		begin
			if (tick && (count_reg != {CW{1'b1}}))
				count_reg <= count_reg + 1'b1;
			expired <= strict ? (count_reg > limit)
				: (count_reg >= limit);
		end
	end

endmodule // cls_loss_timer

// [hdl/cls_supervisor.v]
// panel and fieldbus communication loss supervisor
// ------------------------------------------------------------
// Behaviour
// - panel rate codes 1..5 select 38.4..230.4 kbit/s, default 4.
// - panel reaction fires only after a break longer than the timeout.
// - panel timeout counts tenths of a second, default 100.
// - panel reaction defaults to trip; code 0 ignores the break.
// - panel code 1 trips with fault code 7081.
// - panel code 2 warns and holds the 850 ms filtered speed.
// - panel code 3 warns and commands safe speed or safe frequency.
// - panel settings take effect only when apply is written with 1.
// - apply clears itself back to done after it has executed.
// - adapter enable defaults off; code 1 talks to slot one.
// - fieldbus reaction defaults to none; delay is its own setting.
// - fieldbus code 1 trips with code 7510 and coasts to stop.
// - fieldbus timer runs while no message update arrives.
// - fieldbus code 5 only warns.
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "cls_defs.vh"

module cls_supervisor
#(
	parameter TICK_CYC = `CLS_TICK_CYC,
	parameter FILT_CYC = `CLS_FILT_CYC
)
(
	// clock and reset
	input  wire        mclk,
	input  wire        srst,
	// register port
	input  wire [7:0]  regAddr,
	input  wire [15:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [15:0] regRdData,
	// link activity
	input  wire        panelMsgValid,
	input  wire        fbMsgValid,
	// drive side
	input  wire [15:0] actualSpeed,
	input  wire        freqRefMode,
	input  wire        faultResetReq,
	// panel link settings in use
	output reg  [15:0] panelNodeId,
	output reg  [2:0]  panelRate,
	output reg         panelReconfig,
	// adapter
	output wire        fbEnabled,
	output wire [1:0]  fbSlot,
	// reactions
	output reg         trip,
	output reg         coastStop,
	output reg  [15:0] faultCode,
	output reg         panelWarning,
	output reg         fbWarning,
	output reg  [15:0] warnCode,
	output reg         speedOverride,
	output reg  [15:0] speedCmd
);

	// --------------------------------------------------------
	// staged and active settings
	// --------------------------------------------------------
	reg  [15:0] nodeStage_reg;
	reg  [2:0]  rateStage_reg;
	reg  [15:0] pTimeStage_reg;
	reg  [2:0]  pReactStage_reg;
	reg  [15:0] pTime_reg;
	reg  [2:0]  pReact_reg;
	reg         apply_reg;
	reg         apply_next;
	reg         fbEn_reg;
	reg  [2:0]  fbReact_reg;
	reg  [15:0] fbDelay_reg;
	reg  [15:0] safeSpd_reg;
	reg  [15:0] safeFrq_reg;

	wire wrNode  = regWr && (regAddr == `CLS_OFS_NODE);
	wire wrRate  = regWr && (regAddr == `CLS_OFS_RATE);
	wire wrPTime = regWr && (regAddr == `CLS_OFS_PTIMEOUT);
	wire wrPReac = regWr && (regAddr == `CLS_OFS_PREACT);
	wire wrApply = regWr && (regAddr == `CLS_OFS_APPLY);
	wire rateOk  = (regWrData[2:0] >= `CLS_RATE_MIN)
		&& (regWrData[2:0] <= `CLS_RATE_MAX)
		&& (regWrData[15:3] == 13'h0000);

	// a new request written in the clearing cycle is kept
	always @*
	begin
		if (wrApply)
			apply_next = regWrData[0];
		else if (apply_reg)
			apply_next = `CLS_APPLY_DONE;
		else
			apply_next = apply_reg;
	end

	always @(posedge mclk)
	begin
		if (srst)
		begin
			nodeStage_reg   <= `CLS_RST_NODE;
			rateStage_reg   <= `CLS_RST_RATE;
			pTimeStage_reg  <= `CLS_RST_PTIMEOUT;
			pReactStage_reg <= `CLS_RST_PREACT;
			panelNodeId     <= `CLS_RST_NODE;
			panelRate       <= `CLS_RST_RATE;
			pTime_reg       <= `CLS_RST_PTIMEOUT;
			pReact_reg      <= `CLS_RST_PREACT;
			apply_reg       <= `CLS_APPLY_DONE;
			panelReconfig   <= 1'b0;
			fbEn_reg        <= 1'b0;
			fbReact_reg     <= `CLS_RST_FBREACT;
			fbDelay_reg     <= `CLS_RST_FBDELAY;
			safeSpd_reg     <= 16'h0000;
			safeFrq_reg     <= 16'h0000;
		end
		else
		begin
			if (wrNode)
				nodeStage_reg <= regWrData;
			if (wrRate && rateOk)
				rateStage_reg <= regWrData[2:0];
			if (wrPTime)
				pTimeStage_reg <= regWrData;
			if (wrPReac && (regWrData[15:2] == 14'h0000))
				pReactStage_reg <= regWrData[2:0];
			apply_reg     <= apply_next;
			panelReconfig <= apply_reg;
			if (apply_reg)
			begin
				panelNodeId <= nodeStage_reg;
				panelRate   <= rateStage_reg;
				pTime_reg   <= pTimeStage_reg;
				pReact_reg  <= pReactStage_reg;
			end
			if (regWr && (regAddr == `CLS_OFS_FBEN))
				fbEn_reg <= regWrData[0];
			if (regWr && (regAddr == `CLS_OFS_FBREACT)
				&& (regWrData[15:0] <= 16'h0005))
				fbReact_reg <= regWrData[2:0];
			if (regWr && (regAddr == `CLS_OFS_FBDELAY))
				fbDelay_reg <= regWrData;
			if (regWr && (regAddr == `CLS_OFS_SAFESPD))
				safeSpd_reg <= regWrData;
			if (regWr && (regAddr == `CLS_OFS_SAFEFRQ))
				safeFrq_reg <= regWrData;
		end
	end

	assign fbEnabled = fbEn_reg;
	assign fbSlot    = {1'b0, fbEn_reg};

	// --------------------------------------------------------
	// tenth-second tick and filter tick
	// --------------------------------------------------------
	reg  [31:0] tickCnt_reg;
	reg  [31:0] filtCnt_reg;
	reg         tick_reg;
	reg         filtTick_reg;

	always @(posedge mclk)
	begin
		if (srst)
		begin
			tickCnt_reg  <= 32'h0000_0000;
			filtCnt_reg  <= 32'h0000_0000;
			tick_reg     <= 1'b0;
			filtTick_reg <= 1'b0;
		end
		else
		begin
			tick_reg     <= (tickCnt_reg == TICK_CYC - 1);
			filtTick_reg <= (filtCnt_reg == FILT_CYC - 1);
			if (tickCnt_reg == TICK_CYC - 1)
				tickCnt_reg <= 32'h0000_0000;
			else
				tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
			if (filtCnt_reg == FILT_CYC - 1)
				filtCnt_reg <= 32'h0000_0000;
			else
				filtCnt_reg <= filtCnt_reg + 32'h0000_0001;
		end
	end

	// --------------------------------------------------------
	// break timers, channel 0 panel, channel 1 fieldbus
	// --------------------------------------------------------
	wire [1:0]  chArmed;
	wire [1:0]  chMsg;
	wire [1:0]  chStrict;
	wire [31:0] chLimit;
	wire [1:0]  chExp;

	assign chArmed  = {fbEn_reg && (fbReact_reg != `CLS_RE_NONE),
		pReact_reg != `CLS_RE_NONE};
	assign chMsg    = {fbMsgValid, panelMsgValid};
	// panel waits for longer than, fieldbus reacts on reaching
	assign chStrict = 2'b01;
	assign chLimit  = {fbDelay_reg, pTime_reg};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : gTimer
			cls_loss_timer #(.CW(16)) uTimer
			(
				.mclk    (mclk),
				.srst    (srst),
				.armed   (chArmed[gi]),
				.tick    (tick_reg),
				.restart (chMsg[gi]),
				.limit   (chLimit[gi*16 +: 16]),
				.strict  (chStrict[gi]),
				.expired (chExp[gi])
			);
		end
	endgenerate

	wire panelLoss = chExp[0];
	wire fbLoss    = chExp[1];

	// --------------------------------------------------------
	// 850 ms low-pass of actual speed
	// --------------------------------------------------------
	reg  signed [19:0] filtAcc_reg;
	wire signed [19:0] spdExt = {{4{actualSpeed[15]}}, actualSpeed};
	wire [15:0]        filtSpeed = filtAcc_reg[19:4];

	// one shift per step keeps it multiplier free
	always @(posedge mclk)
	begin
		if (srst)
			filtAcc_reg <= 20'sh0_0000;
		else if (filtTick_reg)
			filtAcc_reg <= filtAcc_reg + spdExt
				- (filtAcc_reg >>> `CLS_FILT_SHIFT);
	end

	// --------------------------------------------------------
	// reactions
	// --------------------------------------------------------
	wire pTrip  = panelLoss && (pReact_reg == `CLS_RE_FAULT);
	wire fbTrip = fbLoss && ((fbReact_reg == `CLS_RE_FAULT)
		|| (fbReact_reg == `CLS_RE_FAULTALL));
	wire pLast  = panelLoss && (pReact_reg == `CLS_RE_LAST);
	wire pSafe  = panelLoss && (pReact_reg == `CLS_RE_SAFE);
	wire fLast  = fbLoss && (fbReact_reg == `CLS_RE_LAST);
	wire fSafe  = fbLoss && (fbReact_reg == `CLS_RE_SAFE);
	wire fWarn  = fbLoss && (fbReact_reg == `CLS_RE_WARN);
	wire lastC  = pLast || fLast;
	wire safeC  = pSafe || fSafe;
	reg         lastDly_reg;

	always @(posedge mclk)
	begin
		if (srst)
		begin
			trip          <= 1'b0;
			coastStop     <= 1'b0;
			faultCode     <= 16'h0000;
			panelWarning  <= 1'b0;
			fbWarning     <= 1'b0;
			warnCode      <= 16'h0000;
			speedOverride <= 1'b0;
			speedCmd      <= 16'h0000;
			lastDly_reg   <= 1'b0;
		end
		else
		begin
			// a new break wins over a reset in the same cycle
			if (pTrip && !trip)
			begin
				trip      <= 1'b1;
				faultCode <= `CLS_FC_PANEL;
			end
			else if (fbTrip && !trip)
			begin
				trip      <= 1'b1;
				coastStop <= 1'b1;
				faultCode <= `CLS_FC_FIELDBUS;
			end
			else if (faultResetReq && !pTrip && !fbTrip)
			begin
				trip      <= 1'b0;
				coastStop <= 1'b0;
				faultCode <= 16'h0000;
			end
			panelWarning <= pLast || pSafe;
			fbWarning    <= fLast || fSafe || fWarn;
			if (pLast || pSafe)
				warnCode <= `CLS_WC_PANEL;
			else if (fLast || fSafe || fWarn)
				warnCode <= `CLS_WC_FIELDBUS;
			else
				warnCode <= 16'h0000;
			lastDly_reg   <= lastC;
			speedOverride <= lastC || safeC;
			// safe speed outranks the frozen speed
			if (safeC)
				speedCmd <= freqRefMode ? safeFrq_reg
					: safeSpd_reg;
			else if (lastC && !lastDly_reg)
				speedCmd <= filtSpeed;
			else if (!lastC)
				speedCmd <= 16'h0000;
		end
	end

	// --------------------------------------------------------
	// register read, data one cycle after the strobe
	// --------------------------------------------------------
	always @(posedge mclk)
	begin
		if (srst)
			regRdData <= 16'h0000;
		else if (regRd)
		begin
			case (regAddr)
				`CLS_OFS_NODE:     regRdData <= nodeStage_reg;
				`CLS_OFS_RATE:     regRdData <= {13'h0000, rateStage_reg};
				`CLS_OFS_PTIMEOUT: regRdData <= pTimeStage_reg;
				`CLS_OFS_PREACT:   regRdData <= {13'h0000, pReactStage_reg};
				`CLS_OFS_APPLY:    regRdData <= {15'h0000, apply_reg};
				`CLS_OFS_FBEN:     regRdData <= {15'h0000, fbEn_reg};
				`CLS_OFS_FBREACT:  regRdData <= {13'h0000, fbReact_reg};
				`CLS_OFS_FBDELAY:  regRdData <= fbDelay_reg;
				`CLS_OFS_STATUS:   regRdData <= {9'h000, speedOverride,
					coastStop, fbWarning, panelWarning, trip,
					fbLoss, panelLoss};
				`CLS_OFS_FAULT:    regRdData <= faultCode;
				`CLS_OFS_SAFESPD:  regRdData <= safeSpd_reg;
				`CLS_OFS_SAFEFRQ:  regRdData <= safeFrq_reg;
				`CLS_OFS_FILT:     regRdData <= filtSpeed;
				default:           regRdData <= 16'h0000;
			endcase
		end
		else
			regRdData <= 16'h0000;
	end

endmodule // cls_supervisor

// [verification/cls_link_model.sv]
// message sources standing in for the panel tool and the adapter
`timescale 1ns/1ps

module cls_link_model
(
	// clock and reset
	input wire  mclk,
	input wire  srst,
	// control
	input wire  panelOn,
	input wire  fbOn,
	input wire  panelReconfig,
	// messages
	output reg  panelMsgValid,
	output reg  fbMsgValid
);
	reg [2:0] phase_reg;
	reg [2:0] hold_reg;

	always @(posedge mclk)
	begin
		phase_reg     <= (srst || phase_reg == 3'h4) ? 3'h0 : phase_reg + 3'h1;
		// link drops on reconfig, so reconnect after a pause
		// reset keeps the pause counter from staying unknown
		if (srst)
			hold_reg <= 3'h0;
		else if (panelReconfig)
			hold_reg <= 3'h4;
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
		panelMsgValid <= !srst && panelOn && hold_reg == 3'h0 &&
			phase_reg == 3'h0;
		fbMsgValid    <= !srst && fbOn && phase_reg == 3'h2;
	end
endmodule // cls_link_model

// [verification/cls_supervisor_asserts.sv]
// concurrent checks on the supervisor ports
`timescale 1ns/1ps

module cls_supervisor_chk
(
	// clock and reset
	input wire        mclk,
	input wire        srst,
	// register port
	input wire [7:0]  regAddr,
	input wire [15:0] regWrData,
	input wire        regWr,
	input wire        regRd,
	input wire [15:0] regRdData,
	// settings and reactions
	input wire        panelReconfig,
	input wire [2:0]  panelRate,
	input wire        fbEnabled,
	input wire [1:0]  fbSlot,
	input wire        trip,
	input wire        coastStop,
	input wire [15:0] faultCode,
	input wire        panelWarning,
	input wire        fbWarning,
	input wire [15:0] warnCode,
	input wire        speedOverride
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// apply sequence
	// ------------------------------------------------------------
	sequence sApply;
		regWr && regAddr == 8'h10 && regWrData[0];
	endsequence
	sequence sReconf;
		##2 panelReconfig ##1 !panelReconfig;
	endsequence

	AST_APPLY: assert property (sApply |-> sReconf)
		else $error("apply gave no single reconfig pulse");
	AST_RATEHOLD: assert property ($changed(panelRate) |-> panelReconfig)
		else $error("rate changed without apply");
	AST_RATE: assert property (panelRate >= 3'h1 && panelRate <= 3'h5)
		else $error("rate code out of range");
	AST_RDIDLE: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data outside its cycle");
	AST_SLOT: assert property (fbSlot == {1'b0, fbEnabled})
		else $error("slot does not follow enable");
	AST_TRIPCODE: assert property ($rose(trip) |->
		faultCode == 16'h7081 || faultCode == 16'h7510)
		else $error("trip without loss code");
	AST_COAST: assert property ($rose(coastStop) |->
		trip && faultCode == 16'h7510)
		else $error("coast without fieldbus trip");
	AST_PWARN: assert property (panelWarning |-> warnCode == 16'hA7EE)
		else $error("panel warning code wrong");
	AST_FBWARN: assert property (fbWarning && !panelWarning |->
		warnCode == 16'hA7C1)
		else $error("fieldbus warning code wrong");
	AST_OVR: assert property (speedOverride |-> panelWarning || fbWarning)
		else $error("override without warning");
endmodule // cls_supervisor_chk

bind cls_supervisor cls_supervisor_chk u_chk
(
	.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.panelReconfig(panelReconfig), .panelRate(panelRate),
	.fbEnabled(fbEnabled), .fbSlot(fbSlot), .trip(trip),
	.coastStop(coastStop), .faultCode(faultCode),
	.panelWarning(panelWarning), .fbWarning(fbWarning),
	.warnCode(warnCode), .speedOverride(speedOverride)
);

// [verification/cls_supervisor_tb_top.sv]
// testbench for the communication loss supervisor
`timescale 1ns/1ps

module cls_supervisor_tb_top;
	reg         mclk;
	reg         srst;
	reg  [7:0]  regAddr;
	reg  [15:0] regWrData;
	reg         regWr;
	reg         regRd;
	reg  [15:0] actualSpeed;
	reg         freqRefMode;
	reg         faultResetReq;
	reg         panelOn;
	reg         fbOn;
	wire [15:0] regRdData;
	wire        panelMsgValid;
	wire        fbMsgValid;
	wire [15:0] panelNodeId;
	wire [2:0]  panelRate;
	wire        panelReconfig;
	wire        fbEnabled;
	wire [1:0]  fbSlot;
	wire        trip;
	wire        coastStop;
	wire [15:0] faultCode;
	wire        panelWarning;
	wire        fbWarning;
	wire [15:0] warnCode;
	wire        speedOverride;
	wire [15:0] speedCmd;
	int         badCount;
	int         checks;
	int         i;
	int         r;

	// short tick and filter so a break resolves in tens of cycles
	cls_supervisor #(.TICK_CYC(10), .FILT_CYC(4)) uut
	(
		.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.panelMsgValid(panelMsgValid), .fbMsgValid(fbMsgValid),
		.actualSpeed(actualSpeed), .freqRefMode(freqRefMode),
		.faultResetReq(faultResetReq), .panelNodeId(panelNodeId),
		.panelRate(panelRate), .panelReconfig(panelReconfig),
		.fbEnabled(fbEnabled), .fbSlot(fbSlot), .trip(trip),
		.coastStop(coastStop), .faultCode(faultCode),
		.panelWarning(panelWarning), .fbWarning(fbWarning),
		.warnCode(warnCode), .speedOverride(speedOverride),
		.speedCmd(speedCmd)
	);

	cls_link_model u_link
	(
		.mclk(mclk), .srst(srst), .panelOn(panelOn), .fbOn(fbOn),
		.panelReconfig(panelReconfig), .panelMsgValid(panelMsgValid),
		.fbMsgValid(fbMsgValid)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input string n, input [15:0] s, input [15:0] e);
		checks++;
		if (s !== e)
		begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task wr(input [7:0] a, input [15:0] d);
		@(posedge mclk);
		regWr     <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task rd(input [7:0] a, input [15:0] e);
		@(posedge mclk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), regRdData, e);
	endtask

	task waitTrip;
		for (i = 0; i < 80 && trip !== 1'b1; i++)
			idle(1);
	endtask

	// the timer must see messages again before the reset is honoured
	task clearTrip;
		idle(10);
		faultResetReq <= 1'b1;
		idle(2);
		faultResetReq <= 1'b0;
		idle(2);
		chk("trip", trip, 16'h0000);
		chk("coast", coastStop, 16'h0000);
		chk("ovr", speedOverride, 16'h0000);
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, watchdog and tests
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		badCount++;
		summarize;
	end

	initial
	begin
		srst          = 1'b1;
		regAddr       = 8'h00;
		regWrData     = 16'h0000;
		regWr         = 1'b0;
		regRd         = 1'b0;
		actualSpeed   = 16'h0100;
		freqRefMode   = 1'b0;
		faultResetReq = 1'b0;
		panelOn       = 1'b1;
		fbOn          = 1'b0;
		badCount      = 0;
		checks        = 0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rd(8'h00, 16'h0001);
		rd(8'h04, 16'h0004);
		rd(8'h08, 16'h0064);
		rd(8'h0C, 16'h0001);
		rd(8'h14, 16'h0000);
		rd(8'h18, 16'h0000);
		rd(8'h3C, 16'h0000);
		wr(8'h04, 16'h0006);
		rd(8'h04, 16'h0004);
		wr(8'h00, 16'h0007);
		wr(8'h04, 16'h0005);
		wr(8'h08, 16'h0002);
		idle(2);
		chk("rate", panelRate, 16'h0004);
		wr(8'h10, 16'h0001);
		idle(2);
		rd(8'h10, 16'h0000);
		chk("node", panelNodeId, 16'h0007);
		chk("rate", panelRate, 16'h0005);
		$display("test settings done");
		panelOn <= 1'b0;
		idle(15);
		chk("trip", trip, 16'h0000);
		waitTrip;
		chk("code", faultCode, 16'h7081);
		panelOn <= 1'b1;
		clearTrip;
		$display("test panel trip done");
		wr(8'h28, 16'h0123);
		wr(8'h2C, 16'h0456);
		// let the speed filter settle on the constant actual speed
		idle(600);
		rd(8'h30, 16'h0100);
		for (r = 0; r < 3; r++)
		begin
			wr(8'h0C, 16'(r ? r + 1 : 0));
			wr(8'h10, 16'h0001);
			idle(8);
			panelOn <= 1'b0;
			idle(60);
			chk("trip", trip, 16'h0000);
			chk("pwarn", panelWarning, r != 0);
			chk("wcode", warnCode, r ? 16'hA7EE : 16'h0000);
			chk("ovr", speedOverride, r != 0);
			if (r == 1)
			begin
				chk("last", speedCmd, 16'h0100);
				actualSpeed <= 16'h0200;
				idle(20);
				chk("hold", speedCmd, 16'h0100);
				actualSpeed <= 16'h0100;
			end
			if (r == 2)
			begin
				chk("safe", speedCmd, 16'h0123);
				freqRefMode <= 1'b1;
				idle(3);
				chk("sfrq", speedCmd, 16'h0456);
				freqRefMode <= 1'b0;
			end
			panelOn <= 1'b1;
			idle(10);
			chk("pwarn", panelWarning, 16'h0000);
			chk("spd", speedCmd, 16'h0000);
		end
		$display("test panel warnings done");
		wr(8'h14, 16'h0001);
		idle(1);
		chk("fben", fbEnabled, 16'h0001);
		chk("slot", fbSlot, 16'h0001);
		fbOn <= 1'b1;
		wr(8'h18, 16'h0006);
		rd(8'h18, 16'h0000);
		wr(8'h18, 16'h0001);
		idle(100);
		chk("trip", trip, 16'h0000);
		fbOn <= 1'b0;
		idle(15);
		chk("trip", trip, 16'h0000);
		waitTrip;
		chk("code", faultCode, 16'h7510);
		chk("coast", coastStop, 16'h0001);
		fbOn <= 1'b1;
		clearTrip;
		// remaining fieldbus reactions: last speed, safe speed, trip always
		for (r = 2; r < 5; r++)
		begin
			wr(8'h18, 16'(r));
			fbOn <= 1'b0;
			idle(60);
			chk("trip", trip, r == 4);
			chk("coast", coastStop, r == 4);
			chk("fbwarn", fbWarning, r != 4);
			chk("ovr", speedOverride, r != 4);
			chk("wcode", warnCode, r == 4 ? 16'h0000 : 16'hA7C1);
			if (r == 3)
				chk("safe", speedCmd, 16'h0123);
			fbOn <= 1'b1;
			clearTrip;
		end
		wr(8'h18, 16'h0005);
		fbOn <= 1'b0;
		idle(60);
		chk("trip", trip, 16'h0000);
		chk("fbwarn", fbWarning, 16'h0001);
		chk("wcode", warnCode, 16'hA7C1);
		fbOn <= 1'b1;
		$display("test fieldbus done");
		summarize;
	end
endmodule // cls_supervisor_tb_top
